// [rtl/eeprom_device.sv]
// Memory device end: two-wire slave, page buffer, self-timed write and array.
// Assumes the master keeps its side of the bus protocol; reset is power-on.
//
// Implementation choices: the device type code and the write-cycle length.
`timescale 1ns/1ps
module eeprom_device
  import eeprom_link_pkg::*;
#(
  parameter logic [3:0]  TYPE_CODE    = TYPE_CODE_DEFAULT,
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLE_CYCLES
)(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  eeprom_link_if.device    LINK,
  input  wire logic        WRITE_PROTECT,
  input  wire logic        DEVICE_SELECT_BIT0,
  input  wire logic        DEVICE_SELECT_BIT1,
  input  wire logic        DEVICE_SELECT_BIT2,
  output logic             BUSY,
  output logic             STANDBY
);
  localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);
  typedef struct packed {
    dev_phase_t              phase;
    logic [3:0]              bitcnt;
    logic [1:0]              byte_idx;
    logic                    rw;
    logic [7:0]              shift;
    logic [ADDR_W-1:0]       addr;
    logic [ADDR_W-PAGE_W-1:0] wpage;
    logic [PAGE_BYTES-1:0]   mask;
    logic                    busy;
    logic [TW-1:0]           timer;
    logic                    commit;
    logic                    ackd;
    logic                    sda_oe_n;
    logic                    standby;
    logic                    scl_d;
    logic                    sda_d;
  } dev_state_t;
  localparam dev_state_t DEV_RESET = '{
    phase: D_IDLE, bitcnt: '0, byte_idx: '0, rw: 1'b0, shift: '0, addr: '0,
    wpage: '0, mask: '0, busy: 1'b0, timer: '0, commit: 1'b0, ackd: 1'b0,
    sda_oe_n: 1'b1, standby: 1'b1, scl_d: 1'b1, sda_d: 1'b1};
  dev_state_t s;
  dev_state_t next_s;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page_data [PAGE_BYTES];
  logic [1:0] pins_clean;
  logic       scl_f;
  logic       sda_f;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       wr_buf;
  logic [7:0] mem_rd;
  logic [2:0] select;
  pin_filter #(.W(2), .RESET_VAL(2'h3)) u_filter (
    .clock (CLOCK),
    .rst_n (RST_N),
    .ce    (CE),
    .pin   ({LINK.scl, LINK.sda}),
    .clean (pins_clean)
  );
  assign scl_f = pins_clean[1];
  assign sda_f = pins_clean[0];
  assign scl_rise = scl_f & ~s.scl_d;
  assign scl_fall = ~scl_f & s.scl_d;
  assign start_seen = scl_f & s.scl_d & s.sda_d & ~sda_f;
  assign stop_seen  = scl_f & s.scl_d & ~s.sda_d & sda_f;
  assign mem_rd = mem[s.addr];
  assign select = {DEVICE_SELECT_BIT2, DEVICE_SELECT_BIT1, DEVICE_SELECT_BIT0};
  always_comb
  begin
    next_s = s;
    next_s.commit = 1'b0;
    next_s.scl_d = scl_f;
    next_s.sda_d = sda_f;
    wr_buf = 1'b0;
    if (s.commit)
      next_s.mask = '0;
    if (s.busy)
    begin
      next_s.timer = s.timer - 1'b1;
      if (s.timer <= TW'(1))
      begin
        next_s.busy = 1'b0;
        next_s.commit = 1'b1;
      end
    end
    if (start_seen && !s.busy)
    begin
      next_s.phase = D_RX;
      next_s.bitcnt = '0;
      next_s.byte_idx = '0;
      next_s.rw = 1'b0;
      next_s.sda_oe_n = 1'b1;
    end
    else if (stop_seen)
    begin
      next_s.phase = D_IDLE;
      next_s.sda_oe_n = 1'b1;
      if (s.mask != '0 && !s.busy)
      begin
        if (WRITE_PROTECT)
          next_s.mask = '0;
        else
        begin
          next_s.busy = 1'b1;
          next_s.timer = TW'(WRITE_CYCLES);
        end
      end
    end
    else
    begin
      case (s.phase)
        D_RX:
        begin
          if (scl_rise)
          begin
            next_s.shift = {s.shift[6:0], sda_f};
            next_s.bitcnt = s.bitcnt + 1'b1;
          end
          else if (scl_fall && s.bitcnt == BITS_PER_BYTE)
          begin
            next_s.phase = D_ACK;
            next_s.sda_oe_n = 1'b0;
            case (s.byte_idx)
              2'd0:
              begin
                if (s.shift[7:1] == {TYPE_CODE, select})
                begin
                  next_s.rw = s.shift[0];
                  next_s.byte_idx = 2'd1;
                end
                else
                begin
                  next_s.phase = D_IDLE;
                  next_s.sda_oe_n = 1'b1;
                end
              end
              2'd1:
              begin
                next_s.addr[ADDR_W-1:8] = s.shift[ADDR_W-9:0];
                next_s.byte_idx = 2'd2;
              end
              2'd2:
              begin
                next_s.addr[7:0] = s.shift;
                next_s.byte_idx = 2'd3;
              end
              default:
              begin
                wr_buf = 1'b1;
                next_s.mask[s.addr[PAGE_W-1:0]] = 1'b1;
                if (s.mask == '0)
                  next_s.wpage = s.addr[ADDR_W-1:PAGE_W];
                next_s.addr[PAGE_W-1:0] = s.addr[PAGE_W-1:0] + 1'b1;
              end
            endcase
          end
        end
        D_ACK:
        begin
          if (scl_fall)
          begin
            next_s.bitcnt = '0;
            if (s.rw)
            begin
              next_s.phase = D_TX;
              next_s.shift = mem_rd;
              next_s.sda_oe_n = mem_rd[7];
              next_s.addr = s.addr + 1'b1;
            end
            else
            begin
              next_s.phase = D_RX;
              next_s.sda_oe_n = 1'b1;
            end
          end
        end
        D_TX:
        begin
          if (scl_fall)
          begin
            next_s.bitcnt = s.bitcnt + 1'b1;
            if (s.bitcnt == BITS_PER_BYTE - 4'h1)
            begin
              next_s.phase = D_TXACK;
              next_s.sda_oe_n = 1'b1;
            end
            else
            begin
              next_s.shift = {s.shift[6:0], 1'b1};
              next_s.sda_oe_n = s.shift[6];
            end
          end
        end
        D_TXACK:
        begin
          if (scl_rise)
            next_s.ackd = ~sda_f;
          else if (scl_fall)
          begin
            next_s.bitcnt = '0;
            if (s.ackd)
            begin
              next_s.phase = D_TX;
              next_s.shift = mem_rd;
              next_s.sda_oe_n = mem_rd[7];
              next_s.addr = s.addr + 1'b1;
            end
            else
              next_s.phase = D_IDLE;
          end
        end
        default:
        begin
          next_s.phase = D_IDLE;
          next_s.sda_oe_n = 1'b1;
        end
      endcase
    end
    next_s.standby = (next_s.phase == D_IDLE) && !next_s.busy;
  end
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      s <= DEV_RESET;
    else if (CE)
      s <= next_s;
  end
  // The array is not reset: contents survive like nonvolatile cells.
  always_ff @(posedge CLOCK)
  begin
    if (RST_N && CE)
    begin
      if (wr_buf)
        page_data[s.addr[PAGE_W-1:0]] <= s.shift;
      if (s.commit)
        for (int i = 0; i < PAGE_BYTES; i++)
          if (s.mask[i])
            mem[{s.wpage, PAGE_W'(i)}] <= page_data[i];
    end
  end
  assign LINK.sda_s_o    = 1'b0;
  assign LINK.sda_s_oe_n = s.sda_oe_n;
  assign BUSY            = s.busy;
  assign STANDBY         = s.standby;
endmodule : eeprom_device

// [rtl/eeprom_link_pkg.sv]
// Shared constants, register map and state enumerations for the serial memory link.
// Assumes a 250 MHz system clock on both ends and a pulled-up data line.
package eeprom_link_pkg;
  localparam int unsigned MEM_BYTES      = 8192;
  localparam int unsigned ADDR_W         = 13;
  localparam int unsigned PAGE_BYTES     = 32;
  localparam int unsigned PAGE_W         = 5;
  // Device type code: the value is arbitrary.
  localparam logic [3:0]  TYPE_CODE_DEFAULT = 4'h5;
  localparam int unsigned CLOCK_PERIOD_NS = 4;
  localparam int unsigned WRITE_CYCLE_NS  = 5000000;
  localparam int unsigned WRITE_CYCLE_CYCLES = WRITE_CYCLE_NS / CLOCK_PERIOD_NS;
  localparam int unsigned SCL_MAX_LOW_SUPPLY_HZ = 400000;
  localparam int unsigned SCL_MAX_HZ     = 1000000;
  localparam logic [7:0]  REG_CMD        = 8'h00;
  localparam logic [7:0]  REG_TXDATA     = 8'h04;
  localparam logic [7:0]  REG_RXDATA     = 8'h08;
  localparam logic [7:0]  REG_STATUS     = 8'h0c;
  localparam logic [7:0]  REG_DIVIDER    = 8'h10;
  localparam int unsigned CMD_START      = 0;
  localparam int unsigned CMD_STOP       = 1;
  localparam int unsigned CMD_WRITE      = 2;
  localparam int unsigned CMD_READ       = 3;
  localparam int unsigned CMD_NACK       = 4;
  localparam int unsigned STAT_BUSY      = 0;
  localparam int unsigned STAT_ACK       = 1;
  localparam logic [15:0] DIVIDER_RESET  = 16'h003f;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK} dev_phase_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BIT} host_phase_t;
endpackage : eeprom_link_pkg

// [rtl/eeprom_link_if.sv]
// Two-wire link between the bus master and the memory device.
// Both data drivers are open drain; the line floats high through a pull-up.
`timescale 1ns/1ps
interface eeprom_link_if;
  logic scl;
  logic sda;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;

  // A driver pulls low only when its enable is low and its output is low.
  assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

  modport device (input scl, input sda, output sda_s_o, output sda_s_oe_n);
  modport master (output scl, input sda, output sda_m_o, output sda_m_oe_n);
endinterface : eeprom_link_if

// [rtl/pin_filter.sv]
// Three-stage input synchroniser with agreement filter for asynchronous pins.
// Assumes pins idle at the reset value given by the parameter.
`timescale 1ns/1ps
module pin_filter
  import eeprom_link_pkg::*;
#(
  parameter int unsigned W         = 2,
  parameter logic [1:0]  RESET_VAL = 2'h3
)(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] clean
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          s1[g]    <= RESET_VAL[g];
          s2[g]    <= RESET_VAL[g];
          s3[g]    <= RESET_VAL[g];
          clean[g] <= RESET_VAL[g];
        end
        else if (ce)
        begin
          s1[g] <= pin[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          // A change counts only once two settled stages agree.
          if (s2[g] == s3[g])
            clean[g] <= s3[g];
        end
      end
    end
  endgenerate
endmodule : pin_filter

// [rtl/eeprom_bus_master.sv]
// Bus master end: APB register slave driving byte-level start, stop and transfers.
// Assumes the slave never stretches the clock; software sequences the commands.
`timescale 1ns/1ps
module eeprom_bus_master
  import eeprom_link_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  eeprom_link_if.master    LINK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  typedef struct packed {
    host_phase_t phase;
    logic [1:0]  step;
    logic [15:0] divcnt;
    logic [15:0] divider;
    logic [3:0]  bitcnt;
    logic [8:0]  shift;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic        ack;
    logic        scl;
    logic        sda_oe_n;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } host_state_t;

  localparam host_state_t HOST_RESET = '{
    phase: H_IDLE, step: '0, divcnt: '0, divider: DIVIDER_RESET, bitcnt: '0,
    shift: '0, tx: '0, rx: '0, ack: 1'b0, scl: 1'b1, sda_oe_n: 1'b1,
    prdata: '0, pready: 1'b0, pslverr: 1'b0};

  host_state_t s;
  host_state_t next_s;
  logic        sda_f;
  logic        tick;
  logic        access;
  logic        commit;

  pin_filter #(.W(1), .RESET_VAL(2'h1)) u_filter (
    .clock (CLOCK),
    .rst_n (RST_N),
    .ce    (CE),
    .pin   (LINK.sda),
    .clean (sda_f)
  );

  assign tick   = (s.divcnt == '0);
  assign access = PSEL & PENABLE & ~s.pready;
  assign commit = PSEL & PENABLE & s.pready;

  always_comb
  begin
    next_s = s;
    next_s.pready = 1'b0;
    if (access)
    begin
      next_s.pready = 1'b1;
      case (PADDR)
        REG_TXDATA:  next_s.prdata = {24'h000000, s.tx};
        REG_RXDATA:  next_s.prdata = {24'h000000, s.rx};
        REG_STATUS:  next_s.prdata = {30'h00000000, s.ack, s.phase != H_IDLE};
        REG_DIVIDER: next_s.prdata = {16'h0000, s.divider};
        default:     next_s.prdata = 32'h00000000;
      endcase
    end
    next_s.divcnt = tick ? s.divider : s.divcnt - 16'h0001;
    if (s.phase != H_IDLE && tick)
    begin
      next_s.step = s.step + 2'd1;
      case (s.phase)
        H_START:
        begin
          case (s.step)
            2'd0: next_s.sda_oe_n = 1'b1;
            2'd1: next_s.scl = 1'b1;
            2'd2: next_s.sda_oe_n = 1'b0;
            default:
            begin
              next_s.scl = 1'b0;
              next_s.phase = H_IDLE;
            end
          endcase
        end
        H_STOP:
        begin
          case (s.step)
            2'd0: next_s.sda_oe_n = 1'b0;
            2'd1: next_s.scl = 1'b1;
            default:
            begin
              next_s.sda_oe_n = 1'b1;
              next_s.phase = H_IDLE;
            end
          endcase
        end
        H_BIT:
        begin
          case (s.step)
            2'd0: next_s.sda_oe_n = s.shift[8];
            2'd1: next_s.scl = 1'b1;
            2'd2: next_s.shift = {s.shift[7:0], sda_f};
            default:
            begin
              next_s.scl = 1'b0;
              next_s.bitcnt = s.bitcnt + 4'h1;
              if (s.bitcnt == BITS_PER_BYTE)
              begin
                next_s.phase = H_IDLE;
                next_s.sda_oe_n = 1'b1;
                next_s.rx = s.shift[8:1];
                next_s.ack = ~s.shift[0];
              end
            end
          endcase
        end
        default: next_s.phase = H_IDLE;
      endcase
    end
    if (commit && PWRITE)
    begin
      case (PADDR)
        REG_TXDATA:  next_s.tx = PWDATA[7:0];
        REG_DIVIDER: next_s.divider = PWDATA[15:0];
        REG_CMD:
        begin
          if (s.phase == H_IDLE && PWDATA[4:0] != 5'h00)
          begin
            next_s.step = '0;
            next_s.bitcnt = '0;
            next_s.divcnt = s.divider;
            if (PWDATA[CMD_START])
              next_s.phase = H_START;
            else if (PWDATA[CMD_STOP])
              next_s.phase = H_STOP;
            else if (PWDATA[CMD_WRITE])
            begin
              next_s.phase = H_BIT;
              next_s.shift = {s.tx, 1'b1};
            end
            else if (PWDATA[CMD_READ])
            begin
              next_s.phase = H_BIT;
              next_s.shift = {8'hff, PWDATA[CMD_NACK]};
            end
          end
        end
        default: next_s.tx = s.tx;
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      s <= HOST_RESET;
    else if (CE)
      s <= next_s;
  end

  assign LINK.scl        = s.scl;
  assign LINK.sda_m_o    = 1'b0;
  assign LINK.sda_m_oe_n = s.sda_oe_n;
  assign PRDATA          = s.prdata;
  assign PREADY          = s.pready;
  assign PSLVERR         = s.pslverr;
endmodule : eeprom_bus_master

// [testbench/eeprom_link_checker.sv]
// Assertions on the shared two-wire link and the device status pins.
// Assumes one clock and one synchronous reset for both ends.
`timescale 1ns/1ps
module eeprom_link_checker
  import eeprom_link_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLE_CYCLES
)(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_o,
  input wire logic sda_s_o,
  input wire logic sda_s_oe_n,
  input wire logic BUSY,
  input wire logic STANDBY
);
  int unsigned busy_len;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // The count restarts whenever no write runs, so it measures one write.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N || !BUSY)
      busy_len <= 0;
    else
      busy_len <= busy_len + 1;
  end
  property p_open_drain;
    sda_s_o == 1'b0 && sda_m_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("driver not open drain");
  property p_reset_quiet;
    disable iff (1'b0) !RST_N |=> sda_s_oe_n && !BUSY && STANDBY;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("not idle in reset");
  property p_busy_released;
    BUSY |-> sda_s_oe_n;
  endproperty
  a_busy_released: assert property (p_busy_released) else $error("drive while busy");
  property p_busy_not_standby;
    BUSY |-> !STANDBY;
  endproperty
  a_busy_not_standby: assert property (p_busy_not_standby) else $error("standby busy");
  property p_standby_after;
    $fell(BUSY) |-> ##[0:4] STANDBY;
  endproperty
  a_standby_after: assert property (p_standby_after) else $error("no standby");
  property p_write_len;
    $fell(BUSY) |-> busy_len >= WRITE_CYCLES && busy_len <= WRITE_CYCLES + 1;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write time wrong");
  property p_write_bound;
    BUSY |-> busy_len <= WRITE_CYCLES;
  endproperty
  a_write_bound: assert property (p_write_bound) else $error("write too long");
  property p_change_scl_low;
    $changed(sda_s_oe_n) |-> !scl;
  endproperty
  a_change_scl_low: assert property (p_change_scl_low) else $error("sda change scl high");
  property p_hold_scl_high;
    scl && $past(scl) |-> $stable(sda_s_oe_n);
  endproperty
  a_hold_scl_high: assert property (p_hold_scl_high) else $error("sda unstable");
  property p_ack_width;
    $fell(sda_s_oe_n) |-> !sda_s_oe_n [*8];
  endproperty
  a_ack_width: assert property (p_ack_width) else $error("low bit too short");
  c_ack: cover property ($fell(sda_s_oe_n));
  c_write: cover property ($rose(BUSY));
  c_start: cover property (scl && $fell(sda));
endmodule : eeprom_link_checker

// [testbench/serial_eeprom_bus_slave_tb_top.sv]
// Bench joining master and device on one link; software side driven over APB.
// Assumes a shortened device write time and a quarter-bit of nine clocks.
`timescale 1ns/1ps
module serial_eeprom_bus_slave_tb_top
  import eeprom_link_pkg::*;
;
  localparam int unsigned WCYC = 200;
  localparam int LIMIT = 80000;
  logic        clock;
  logic        rst_n;
  logic        wp;
  logic [2:0]  sel;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        standby;
  logic [31:0] rng;
  logic [31:0] q;
  logic        ack;
  logic [12:0] base;
  int          fails;
  int          cmp_count;
  int          cyc = 0;
  logic [7:0]  model [int];
  logic [7:0]  wr_q [$];

  eeprom_link_if link();
  eeprom_device #(.WRITE_CYCLES(WCYC)) u_eeprom_device (
    .CLOCK(clock), .RST_N(rst_n), .CE(1'b1), .LINK(link.device), .WRITE_PROTECT(wp),
    .DEVICE_SELECT_BIT0(sel[0]), .DEVICE_SELECT_BIT1(sel[1]), .DEVICE_SELECT_BIT2(sel[2]),
    .BUSY(busy), .STANDBY(standby));
  eeprom_bus_master u_eeprom_bus_master (
    .CLOCK(clock), .RST_N(rst_n), .CE(1'b1), .LINK(link.master), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr));
  eeprom_link_checker #(.WRITE_CYCLES(WCYC)) chk (
    .CLOCK(clock), .RST_N(rst_n), .scl(link.scl), .sda(link.sda), .sda_m_o(link.sda_m_o),
    .sda_s_o(link.sda_s_o), .sda_s_oe_n(link.sda_s_oe_n), .BUSY(busy), .STANDBY(standby));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : next_rand

  function automatic logic [12:0] page_addr(input logic [12:0] a, input int i);
    return {a[12:5], a[4:0] + 5'(i)};
  endfunction : page_addr

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // The request is held until the edge at which ready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only ready or the bench timeout ends this wait.
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    r = prdata;
    check("bus error", pslverr, 1'b0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input int bits);
    logic [31:0] r;
    apb(1'b1, REG_CMD, 32'(bits), r);
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0, r);
    end
    while (r[STAT_BUSY] !== 1'b0);
  endtask : cmd

  task automatic send(input logic [7:0] b, output logic k);
    logic [31:0] r;
    apb(1'b1, REG_TXDATA, {24'h0, b}, r);
    cmd(1 << CMD_WRITE);
    apb(1'b0, REG_STATUS, 32'h0, r);
    k = r[STAT_ACK];
  endtask : send

  task automatic set_ptr(input logic [12:0] a);
    logic k;
    cmd(1 << CMD_START);
    send({TYPE_CODE_DEFAULT, sel, 1'b0}, k);
    check("select ack", k, 1'b1);
    send({3'h0, a[12:8]}, k);
    check("addr hi ack", k, 1'b1);
    send(a[7:0], k);
    check("addr lo ack", k, 1'b1);
  endtask : set_ptr

  task automatic write_page(input logic [12:0] a, input logic keep);
    logic k;
    set_ptr(a);
    foreach (wr_q[i])
    begin
      send(wr_q[i], k);
      check("data ack", k, 1'b1);
      if (keep)
        model[int'(page_addr(a, i))] = wr_q[i];
    end
    cmd(1 << CMD_STOP);
  endtask : write_page

  task automatic read_seq(input logic [12:0] a, input int n);
    logic        k;
    logic [31:0] r;
    set_ptr(a);
    cmd(1 << CMD_START);
    send({TYPE_CODE_DEFAULT, sel, 1'b1}, k);
    check("read select ack", k, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      cmd((1 << CMD_READ) | (int'(i == n - 1) << CMD_NACK));
      apb(1'b0, REG_RXDATA, 32'h0, r);
      check("read data", r[7:0], model[int'(13'(a + i))]);
    end
    cmd(1 << CMD_STOP);
  endtask : read_seq

  // The poll start falls inside the short write, so the byte must go unanswered.
  task automatic post_write();
    logic k;
    // The stop reaches the device through its pin filter a few clocks late.
    repeat (8) @(posedge clock);
    check("busy after stop", busy, 1'b1);
    check("standby while busy", standby, 1'b0);
    cmd(1 << CMD_START);
    send({TYPE_CODE_DEFAULT, sel, 1'b0}, k);
    check("poll ack", k, 1'b0);
    cmd(1 << CMD_STOP);
    while (busy !== 1'b0)
    begin
      @(posedge clock);
    end
    repeat (5) @(posedge clock);
    check("standby after write", standby, 1'b1);
  endtask : post_write

  task automatic init();
    logic [31:0] r;
    rst_n <= 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check("standby at reset", standby, 1'b1);
    check("busy at reset", busy, 1'b0);
    apb(1'b0, REG_DIVIDER, 32'h0, r);
    check("divider reset", r, 32'(DIVIDER_RESET));
    apb(1'b1, REG_DIVIDER, 32'h8, r);
  endtask : init

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fails++;
      give_verdict();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    wp = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    fails = 0;
    cmp_count = 0;
    rng = next_rand(32'h14bd);
    sel = rng[2:0];
    init();
    apb(1'b0, 8'h20, 32'h0, q);
    check("unmapped read", q, 32'h0);
    apb(1'b0, REG_DIVIDER, 32'h0, q);
    check("divider rw", q, 32'h8);
    $display("reset and registers done");
    for (int i = 0; i < 9; i++)
    begin
      cmd(1 << CMD_START);
      send((i < 8) ? {TYPE_CODE_DEFAULT, 3'(i), 1'b0} : {~TYPE_CODE_DEFAULT, sel, 1'b0}, ack);
      check("select match", ack, (i < 8) && (3'(i) == sel));
      cmd(1 << CMD_STOP);
    end
    $display("device select done");
    rng = next_rand(rng);
    base = {rng[12:5], 5'h1e};
    for (int i = 0; i < 4; i++)
    begin
      rng = next_rand(rng);
      wr_q.push_back(rng[7:0]);
    end
    write_page(base, 1'b1);
    post_write();
    read_seq(base, 2);
    read_seq(page_addr(base, 2), 2);
    $display("page write wrap done");
    wr_q.delete();
    wr_q.push_back(~model[int'(page_addr(base, 1))]);
    write_page(page_addr(base, 1), 1'b1);
    post_write();
    read_seq(base, 2);
    $display("partial page done");
    wp <= 1'b1;
    wr_q[0] = ~model[int'(base)];
    write_page(base, 1'b0);
    repeat (40) @(posedge clock);
    check("busy under protect", busy, 1'b0);
    wp <= 1'b0;
    read_seq(base, 1);
    $display("write protect done");
    write_page(base, 1'b0);
    repeat (8) @(posedge clock);
    check("busy before abort", busy, 1'b1);
    init();
    read_seq(base, 1);
    $display("reset during write done");
    give_verdict();
  end
endmodule : serial_eeprom_bus_slave_tb_top
